// ===== pkg/tsm_pkg.sv
// tsm_pkg: constants and types for the timer slave-mode trigger controller
package tsm_pkg;

    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int CNT_W  = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // ---------------------------------------------------------------
    // register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_SLAVE  = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CHAN   = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hC;

    // ---------------------------------------------------------------
    // control register fields
    // ---------------------------------------------------------------
    localparam int B_CEN  = 0;
    localparam int B_URS  = 1;
    localparam int B_XOR  = 2;
    localparam int B_CC_CONTROL_PRELOAD = 3;
    localparam int B_CC_CONTROL_UPDATE_SELECT = 4;
    localparam int B_TIE  = 5;
    localparam int B_TDE  = 6;
    localparam int F_MMS  = 8;   // 3 bits
    localparam int F_CH2_OUTPUT_MODE = 12;  // 3 bits
    localparam int F_ARR  = 16;  // 16 bits

    // ---------------------------------------------------------------
    // slave register fields
    // ---------------------------------------------------------------
    localparam int F_SMS  = 0;   // 3 bits
    localparam int F_TS   = 4;   // 3 bits
    localparam int F_ETF  = 8;   // 4 bits
    localparam int F_EXT_TRIGGER_PRESCALER = 12;  // 2 bits
    localparam int B_ETP  = 14;
    localparam int B_ECE  = 15;
    localparam int F_CMP2 = 16;  // 16 bits

    // ---------------------------------------------------------------
    // channel register fields
    // ---------------------------------------------------------------
    localparam int F_CH1_DIRECTION_SELECT = 0;   // 2 bits
    localparam int F_CH2_DIRECTION_SELECT = 2;   // 2 bits
    localparam int B_CH1_POLARITY = 4;
    localparam int B_CH2_POLARITY = 5;
    localparam int F_CH1_INPUT_FILTER = 8;   // 4 bits

    // status bits (write one to clear flag)
    localparam int B_TIF  = 0;
    localparam int B_RUN  = 1;
    localparam int F_CAP  = 16;

    // ---------------------------------------------------------------
    // encodings
    // ---------------------------------------------------------------
    localparam logic [2:0] SMS_RESET = 3'h4;
    localparam logic [2:0] SMS_GATED = 3'h5;
    localparam logic [2:0] SMS_TRIG  = 3'h6;
    localparam logic [2:0] TS_CH1    = 3'h5;
    localparam logic [2:0] TS_CH2    = 3'h6;
    localparam logic [2:0] TS_ETR    = 3'h7;
    localparam logic [2:0] MMS_OC2   = 3'h5;
    localparam logic [2:0] OCM_PWM2  = 3'h7;
    localparam logic [1:0] CCS_OUT   = 2'h0;
    localparam logic [1:0] CCS_OWN   = 2'h1;
    localparam logic [1:0] CCS_TRC   = 2'h3;
    localparam logic [3:0] FILT_NONE = 4'h0;
    localparam logic [1:0] PSC_OFF   = 2'h0;

    localparam logic [DATA_W-1:0] CTRL_RST  = 32'hFFFF0000;
    localparam logic [DATA_W-1:0] ZERO_W    = 32'h00000000;
    localparam logic [CNT_W-1:0]  CNT_ZERO  = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;
    localparam logic [3:0]        FCNT_ZERO = 4'h0;
    localparam logic [3:0]        FCNT_ONE  = 4'h1;

    // state of the counter enable sequencer
    typedef enum logic [1:0] {TSM_IDLE, TSM_RUN} tsm_run_t;

endpackage

// ===== sim/tsm_ctrl_sva.sv
// tsm_ctrl_sva: port-level assertions for the slave-mode controller
`timescale 1ns/100ps
`default_nettype none
module tsm_ctrl_sva (
    // clock and reset
    input wire logic                       clk_sys,
    input wire logic                       nrst,
    // register port
    input wire logic [tsm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [tsm_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                       reg_wr,
    // event outputs
    input wire logic                       trigger_irq,
    input wire logic                       trigger_dma,
    input wire logic                       update_event,
    input wire logic                       commutation_event,
    input wire logic                       master_trigger_out,
    input wire logic [tsm_pkg::CNT_W-1:0]  count_out
);
    import tsm_pkg::*;
    // ------------------------------------------------------------
    // shadow of the configuration written by software
    // ------------------------------------------------------------
    logic tie_q, oc2_q, com_q, cen_q, gat_q;
    logic tie_d, oc2_d, com_d, cen_d, gat_d;
    // follow control and slave register writes
    always_comb begin
        {tie_d, oc2_d, com_d, cen_d} = {tie_q, oc2_q, com_q, cen_q};
        gat_d = gat_q;
        if (reg_wr && reg_addr == OFS_CTRL) begin
            tie_d = reg_wdata[B_TIE];
            oc2_d = reg_wdata[F_MMS+:3] == MMS_OC2;
            com_d = reg_wdata[B_CC_CONTROL_PRELOAD] && reg_wdata[B_CC_CONTROL_UPDATE_SELECT];
            cen_d = reg_wdata[B_CEN];
        end
        if (reg_wr && reg_addr == OFS_SLAVE) begin
            gat_d = reg_wdata[F_SMS+:3] == SMS_GATED;
        end
    end
    // register the shadow bits
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            {tie_q, oc2_q, com_q, cen_q, gat_q} <= 5'h00;
        end else begin
            {tie_q, oc2_q, com_q, cen_q, gat_q} <=
                {tie_d, oc2_d, com_d, cen_d, gat_d};
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // gated mode held off by software for two cycles
    sequence s_gate_off;
        (gat_q && !cen_q) ##1 (gat_q && !cen_q);
    endsequence
    a_dma_pulse: assert property (trigger_dma |=> !trigger_dma)
        else $error("dma request longer than one cycle");
    a_irq_enable: assert property (
        trigger_irq |-> tie_q || $past(tie_q))
        else $error("interrupt without its enable");
    a_uev_pulse: assert property (update_event |=> !update_event)
        else $error("update event longer than one cycle");
    a_com_pulse: assert property (
        commutation_event |=> !commutation_event)
        else $error("commutation longer than one cycle");
    a_com_enable: assert property (
        commutation_event |-> com_q || $past(com_q))
        else $error("commutation without preload and select");
    a_count_step: assert property ($changed(count_out) |->
        count_out == CNT_ZERO || count_out == $past(count_out) + CNT_ONE)
        else $error("counter jumped");
    a_mto_mode: assert property (
        master_trigger_out |-> oc2_q || $past(oc2_q))
        else $error("trigger output high outside compare mode");
    a_gate_hold: assert property (
        s_gate_off |-> $stable(count_out))
        else $error("gated counter ran with enable clear");
endmodule
`default_nettype wire

// ===== sim/tsm_ctrl_tb.sv
// tsm_ctrl_tb: register-driven scenarios for the slave-mode controller
`timescale 1ns/100ps
`default_nettype none
module tsm_ctrl_tb;
    import tsm_pkg::*;
    // ------------------------------------------------------------
    // signals, design and pin model
    // ------------------------------------------------------------
    logic              clk_sys   = 1'b0;
    logic              nrst      = 1'b0;
    logic [ADDR_W-1:0] reg_addr  = 4'h0;
    logic [DATA_W-1:0] reg_wdata = 32'h00000000;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic [DATA_W-1:0] reg_rdata, d;
    logic [CNT_W-1:0]  count_out, c0;
    logic              ch1_pin, ch2_pin, ch3_pin, external_trigger_pin;
    logic              trigger_irq, trigger_dma, update_event;
    logic              commutation_event, master_trigger_out;
    logic [2:0]        xv [3] = '{3'h5, 3'h7, 3'h6};
    int                err_count = 0;
    int                total_checks = 0;
    int                n_uev = 0, n_com = 0, n_dma = 0, u0, m0, k0;
    always #10 clk_sys = ~clk_sys;
    tsm_ctrl i_dut (
        .clk_sys              (clk_sys),
        .nrst                 (nrst),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata),
        .ch1_pin              (ch1_pin),
        .ch2_pin              (ch2_pin),
        .ch3_pin              (ch3_pin),
        .external_trigger_pin (external_trigger_pin),
        .trigger_irq          (trigger_irq),
        .trigger_dma          (trigger_dma),
        .update_event         (update_event),
        .commutation_event    (commutation_event),
        .master_trigger_out   (master_trigger_out),
        .count_out            (count_out)
    );
    tsm_pins_model i_pins (
        .clk_sys              (clk_sys),
        .ch1_pin              (ch1_pin),
        .ch2_pin              (ch2_pin),
        .ch3_pin              (ch3_pin),
        .external_trigger_pin (external_trigger_pin)
    );
    // count one-cycle strobes once per cycle
    always @(negedge clk_sys) begin
        n_uev += update_event;
        n_com += commutation_event;
        n_dma += trigger_dma;
    end
    // compare and report a mismatch
    task automatic chk(input logic [31:0] got, exp, input string m);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h",
                     $time, m, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // one-cycle register write
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // one-cycle read, data taken in the following cycle
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        v = reg_rdata;
    endtask
    // 8-cycle reset with pins idle
    task automatic do_reset;
        i_pins.set_ch(3'h0);
        nrst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
    endtask
    // bounded wait for the counter to restart from zero
    task automatic wait_restart(input logic [CNT_W-1:0] c);
        int i;
        for (i = 0; i < 20 && !(count_out < c); i++) @(negedge clk_sys);
        chk(count_out < 16'h0004, 1'b1, "restart");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // watchdog far beyond the few hundred cycles of the tests
    initial begin
        #200000;
        err_count++;
        report_and_stop;
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        do_reset;
        rd(OFS_CTRL, d);
        chk(d, CTRL_RST, "ctrl reset");
        rd(OFS_SLAVE, d);
        chk(d, ZERO_W, "slave reset");
        wr(4'h2, 32'hFFFFFFFF);
        rd(4'h2, d);
        chk(d, ZERO_W, "unmapped");
        $display("test registers done");
        wr(OFS_CHAN, 32'h00000001);
        wr(OFS_SLAVE, 32'h00140054);
        wr(OFS_CTRL, 32'hFFFF7579);
        idle(30);
        c0 = count_out;
        {u0, m0, k0} = {n_uev, n_com, n_dma};
        i_pins.set_ch(3'h1);
        wait_restart(c0);
        idle(4);
        chk(n_uev - u0, 1, "update");
        chk(n_com - m0, 1, "commutation");
        chk(n_dma - k0, 1, "dma");
        chk(trigger_irq, 1'b1, "irq");
        chk(master_trigger_out, 1'b0, "oc2 low");
        rd(OFS_STATUS, d);
        chk(d[B_TIF], 1'b1, "flag");
        chk(d[F_CAP+:16] >= c0, 1'b1, "capture");
        idle(30);
        chk(master_trigger_out, 1'b1, "oc2 high");
        wr(OFS_CTRL, 32'hFFFF757B);
        wr(OFS_STATUS, 32'h00000001);
        i_pins.set_ch(3'h0);
        idle(8);
        chk(trigger_irq, 1'b0, "falling edge");
        c0 = count_out;
        u0 = n_uev;
        i_pins.set_ch(3'h1);
        wait_restart(c0);
        idle(4);
        chk(n_uev - u0, 0, "no update");
        wr(OFS_CTRL, 32'hFFFF757F);
        foreach (xv[i]) begin
            idle(20);
            c0 = count_out;
            i_pins.set_ch(xv[i]);
            wait_restart(c0);
        end
        rd(OFS_STATUS, d);
        chk(d[F_CAP+:16] >= c0, 1'b1, "xor capture");
        $display("test reset mode done");
        do_reset;
        wr(OFS_CHAN, 32'h00000011);
        wr(OFS_SLAVE, 32'h00000055);
        idle(10);
        chk(count_out, CNT_ZERO, "gate enable off");
        wr(OFS_CTRL, 32'hFFFF0001);
        idle(10);
        chk(count_out > CNT_ZERO, 1'b1, "gate counts");
        i_pins.set_ch(3'h1);
        idle(8);
        c0 = count_out;
        idle(5);
        chk(count_out, c0, "gate stops");
        rd(OFS_STATUS, d);
        chk(d[B_TIF], 1'b1, "gate flag");
        $display("test gated mode done");
        do_reset;
        wr(OFS_CHAN, 32'h00000005);
        wr(OFS_SLAVE, 32'h00000066);
        i_pins.set_ch(3'h1);
        idle(10);
        chk(count_out, CNT_ZERO, "channel 1 ignored");
        i_pins.set_ch(3'h3);
        idle(10);
        chk(count_out > CNT_ZERO, 1'b1, "trigger start");
        rd(OFS_STATUS, d);
        chk(d[B_RUN], 1'b1, "hardware enable");
        chk(d[B_TIF], 1'b1, "trigger flag");
        $display("test trigger mode done");
        do_reset;
        wr(OFS_CHAN, 32'h00000001);
        wr(OFS_SLAVE, 32'h00008056);
        i_pins.etr_pulses(3);
        chk(count_out, CNT_ZERO, "clock before trigger");
        i_pins.set_ch(3'h1);
        idle(10);
        chk(count_out, CNT_ZERO, "no internal clock");
        i_pins.etr_pulses(5);
        chk(count_out, 16'h0005, "external clocking");
        $display("test external clock done");
        report_and_stop;
    end
endmodule
bind tsm_ctrl tsm_ctrl_sva i_sva (
    .clk_sys            (clk_sys),
    .nrst               (nrst),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_wr             (reg_wr),
    .trigger_irq        (trigger_irq),
    .trigger_dma        (trigger_dma),
    .update_event       (update_event),
    .commutation_event  (commutation_event),
    .master_trigger_out (master_trigger_out),
    .count_out          (count_out)
);
`default_nettype wire

// ===== sim/tsm_pins_model.sv
// tsm_pins_model: sensor and external trigger pin source for the bench
`timescale 1ns/100ps
`default_nettype none
module tsm_pins_model (
    // clock
    input  wire logic clk_sys,
    // pins driven toward the timer
    output logic      ch1_pin,
    output logic      ch2_pin,
    output logic      ch3_pin,
    output logic      external_trigger_pin
);
    // idle sensors sit low until the bench moves them
    initial {ch1_pin, ch2_pin, ch3_pin, external_trigger_pin} = 4'h0;
    // move the three sensor pins just after a clock edge
    task automatic set_ch(input logic [2:0] v);
        @(posedge clk_sys);
        {ch3_pin, ch2_pin, ch1_pin} <= v;
    endtask
    // n external clock pulses, three cycles a level, then settle
    task automatic etr_pulses(input int n);
        repeat (n) begin
            repeat (3) @(posedge clk_sys);
            external_trigger_pin <= 1'b1;
            repeat (3) @(posedge clk_sys);
            external_trigger_pin <= 1'b0;
        end
        repeat (10) @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ===== verilog/tsm_ctrl.sv
// tsm_ctrl: slave-mode trigger controller of a general-purpose timer
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none

module tsm_ctrl (
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       nrst,
    // register port
    input  wire logic [tsm_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [tsm_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [tsm_pkg::DATA_W-1:0] reg_rdata,
    // timer pins
    input  wire logic                       ch1_pin,
    input  wire logic                       ch2_pin,
    input  wire logic                       ch3_pin,
    input  wire logic                       external_trigger_pin,
    // event outputs
    output logic                            trigger_irq,
    output logic                            trigger_dma,
    output logic                            update_event,
    output logic                            commutation_event,
    output logic                            master_trigger_out,
    output logic      [tsm_pkg::CNT_W-1:0]  count_out
);
    import tsm_pkg::*;

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [DATA_W-1:0] ctrl_q, ctrl_d;
    logic [DATA_W-1:0] slv_q, slv_d;
    logic [DATA_W-1:0] chn_q, chn_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic              tif_q, tif_d;
    logic [CNT_W-1:0]  cap_q, cap_d;

    // synchronisers and filters
    logic [1:0]        s1_q, s1_d;
    logic [1:0]        s2_q, s2_d;
    logic [1:0]        se_q, se_d;
    logic              f1_q, f1_d;
    logic              f2_q, f2_d;
    logic              fe_q, fe_d;
    logic [3:0]        c1_q, c1_d;
    logic [3:0]        ce_q, ce_d;
    logic [2:0]        ep_q, ep_d;      // etr prescaler count
    logic              slave_trigger_in_q, slave_trigger_in_d;
    logic              etrp_q, etrp_d;

    // counter
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    logic [CNT_W-1:0]  arr_q, arr_d;
    logic [CNT_W-1:0]  cmp_q, cmp_d;
    tsm_run_t          st_q, st_d;
    logic              irq_q, irq_d;
    logic              dma_q, dma_d;
    logic              uev_q, uev_d;
    logic              com_q, com_d;
    logic              master_trigger_out_q, master_trigger_out_d;
    logic              oc2_q, oc2_d;
    logic              gate_q, gate_d;

    // combinational helpers
    logic              ti1_raw, ti1fp, ti2fp, etr_s;
    logic              slave_trigger_in, trig_rise, trig_fall, trig_evt;
    logic              ext_tick, tick, etr_edge;
    logic              en, gate_now;
    logic [2:0]        slave_mode_select, ts;

    // decoded fields of the slave register
    assign slave_mode_select = slv_q[F_SMS +: 3];
    assign ts  = slv_q[F_TS +: 3];

    // xor of the three channel pins or channel 1 alone
    assign ti1_raw = ctrl_q[B_XOR] ? (ch1_pin ^ ch2_pin ^ ch3_pin)
                                   : ch1_pin;

    // ---------------------------------------------------------------
    // input conditioning
    // ---------------------------------------------------------------
    // two-stage resync, then a sample-count filter (ch1 and etr only), then polarity
    always_comb begin
        s1_d = {s1_q[0], ti1_raw};
        s2_d = {s2_q[0], ch2_pin};
        se_d = {se_q[0], external_trigger_pin};
        f1_d = f1_q;
        c1_d = FCNT_ZERO;
        if (s1_q[1] == f1_q || chn_q[F_CH1_INPUT_FILTER +: 4] == FILT_NONE) begin
            f1_d = s1_q[1];
        end else begin
            c1_d = c1_q + FCNT_ONE;
            if (c1_d >= chn_q[F_CH1_INPUT_FILTER +: 4]) begin
                f1_d = s1_q[1];
            end
        end
        f2_d = s2_q[1];
        fe_d = fe_q;
        ce_d = FCNT_ZERO;
        if (se_q[1] == fe_q || slv_q[F_ETF +: 4] == FILT_NONE) begin
            fe_d = se_q[1];
        end else begin
            ce_d = ce_q + FCNT_ONE;
            if (ce_d >= slv_q[F_ETF +: 4]) begin
                fe_d = se_q[1];
            end
        end
    end

    assign ti1fp = f1_q ^ chn_q[B_CH1_POLARITY];
    assign ti2fp = f2_q ^ chn_q[B_CH2_POLARITY];
    assign etr_s = fe_q ^ slv_q[B_ETP];
    // trigger source chosen each cycle from conditioned inputs
    assign slave_trigger_in  = (ts == TS_CH1) ? ti1fp :
                   (ts == TS_CH2) ? ti2fp :
                   (ts == TS_ETR) ? etr_s : 1'b0;
    assign trig_rise = slave_trigger_in & ~slave_trigger_in_q;
    assign trig_fall = ~slave_trigger_in & slave_trigger_in_q;
    // reset mode on ch1 with xor on detects both edges: any xor toggle restarts
    // pin to counter: two sync stages, filter flop; the edge is decoded combinationally
    assign trig_evt  = (ts == TS_CH1 && slave_mode_select == SMS_RESET &&
                        ctrl_q[B_XOR]) ? (trig_rise | trig_fall)
                                       : trig_rise;

    // etr edge and prescaler (00 passes every edge, else 1 in 2^n)
    // a three-bit edge count lets prescaler 11 pass one edge in 8
    assign etr_edge = etr_s & ~etrp_q;
    always_comb begin
        ep_d   = ep_q;
        etrp_d = etr_s;
        slave_trigger_in_d = slave_trigger_in;
        if (etr_edge) begin
            ep_d = ep_q + 3'h1;
        end
    end
    assign ext_tick = etr_edge &&
                      (slv_q[F_EXT_TRIGGER_PRESCALER +: 2] == PSC_OFF ||
                       (ep_q & ((3'h1 << slv_q[F_EXT_TRIGGER_PRESCALER +: 2]) - 3'h1)) == 3'h0);
    // external clock mode 2: etr clocks counter, else internal
    assign tick = slv_q[B_ECE] ? ext_tick : 1'b1;

    // ---------------------------------------------------------------
    // slave mode control and counter
    // ---------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        st_d   = st_q;
        cnt_d  = cnt_q;
        arr_d  = arr_q;
        cmp_d  = cmp_q;
        cap_d  = cap_q;
        // software clear first, so a hardware set below wins
        tif_d  = tif_q;
        if (reg_wr && reg_addr == OFS_STATUS && reg_wdata[B_TIF]) begin
            tif_d = 1'b0;
        end
        uev_d  = 1'b0;
        com_d  = 1'b0;
        gate_d = gate_q;
        gate_now = 1'b1;
        case (slave_mode_select)
            SMS_RESET: begin
                if (trig_evt) begin
                    cnt_d = CNT_ZERO;
                    tif_d = 1'b1;
                    cap_d = cnt_q;
                    if (!ctrl_q[B_URS]) begin
                        uev_d = 1'b1;
                        arr_d = ctrl_q[F_ARR +: CNT_W];
                        cmp_d = slv_q[F_CMP2 +: CNT_W];
                    end
                end
            end
            SMS_GATED: begin
                gate_now = slave_trigger_in;
                gate_d   = slave_trigger_in & ctrl_q[B_CEN];
                if (gate_d != gate_q) begin
                    tif_d = 1'b1;
                end
            end
            SMS_TRIG: begin
                if (trig_rise) begin
                    ctrl_d[B_CEN] = 1'b1;
                    tif_d = 1'b1;
                end
            end
            default: ;
        endcase
        // gated mode needs the software enable as well
        en = ctrl_q[B_CEN] & gate_now;
        st_d = en ? TSM_RUN : TSM_IDLE;
        // wrap at auto-reload; a reset-mode trigger that cycle wins
        if (en && tick && !(slave_mode_select == SMS_RESET && trig_evt)) begin
            if (cnt_q >= arr_q) begin
                cnt_d = CNT_ZERO;
                uev_d = 1'b1;
                arr_d = ctrl_q[F_ARR +: CNT_W];
                cmp_d = slv_q[F_CMP2 +: CNT_W];
            end else begin
                cnt_d = cnt_q + CNT_ONE;
            end
        end
        // commutation on trigger rise when control preload and update select are on
        if (ctrl_q[B_CC_CONTROL_PRELOAD] && ctrl_q[B_CC_CONTROL_UPDATE_SELECT] && trig_rise) begin
            com_d = 1'b1;
        end
        // control write; a hardware enable set that cycle still wins
        if (reg_wr && reg_addr == OFS_CTRL) begin
            ctrl_d = reg_wdata;
            if (slave_mode_select == SMS_TRIG && trig_rise) begin
                ctrl_d[B_CEN] = 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // outputs and register read
    // ---------------------------------------------------------------
    always_comb begin
        // slave and channel setup writes
        slv_d = slv_q;
        chn_d = chn_q;
        if (reg_wr && reg_addr == OFS_SLAVE) begin
            slv_d = reg_wdata;
        end
        if (reg_wr && reg_addr == OFS_CHAN) begin
            chn_d = reg_wdata;
        end
        // pwm mode 2: reference high once count reaches compare
        oc2_d = (chn_q[F_CH2_DIRECTION_SELECT +: 2] == CCS_OUT &&
                 ctrl_q[F_CH2_OUTPUT_MODE +: 3] == OCM_PWM2) ?
                (cnt_q >= cmp_q) : 1'b0;
        master_trigger_out_d = (ctrl_q[F_MMS +: 3] == MMS_OC2) ? oc2_q
                                                 : 1'b0;
        // irq follows the flag; dma pulses only on a fresh set
        irq_d = tif_d & ctrl_q[B_TIE];
        dma_d = (tif_d & ~tif_q) & ctrl_q[B_TDE];
        // read data stand for one cycle, zero otherwise
        rdata_d = ZERO_W;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL:   rdata_d = ctrl_q;
                OFS_SLAVE:  rdata_d = slv_q;
                OFS_CHAN:   rdata_d = chn_q;
                OFS_STATUS: begin
                    rdata_d[B_TIF] = tif_q;
                    rdata_d[B_RUN] = (st_q == TSM_RUN);
                    rdata_d[F_CAP +: CNT_W] = cap_q;
                end
                default:    rdata_d = ZERO_W;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // state registers
    // ---------------------------------------------------------------
    // resync stages and input filters
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s1_q   <= 2'h0;
            s2_q   <= 2'h0;
            se_q   <= 2'h0;
            f1_q   <= 1'b0;
            f2_q   <= 1'b0;
            fe_q   <= 1'b0;
            c1_q   <= FCNT_ZERO;
            ce_q   <= FCNT_ZERO;
        end else begin
            s1_q   <= s1_d;
            s2_q   <= s2_d;
            se_q   <= se_d;
            f1_q   <= f1_d;
            f2_q   <= f2_d;
            fe_q   <= fe_d;
            c1_q   <= c1_d;
            ce_q   <= ce_d;
        end
    end

    // etr prescaler count and edge detector history
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ep_q   <= 3'h0;
            slave_trigger_in_q <= 1'b0;
            etrp_q <= 1'b0;
        end else begin
            ep_q   <= ep_d;
            slave_trigger_in_q <= slave_trigger_in_d;
            etrp_q <= etrp_d;
        end
    end

    // counter, flag, shadow values and control register
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RST;
            st_q   <= TSM_IDLE;
            cnt_q  <= CNT_ZERO;
            arr_q  <= CTRL_RST[F_ARR +: CNT_W];
            cmp_q  <= CNT_ZERO;
            cap_q  <= CNT_ZERO;
            tif_q  <= 1'b0;
            uev_q  <= 1'b0;
            com_q  <= 1'b0;
            gate_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            arr_q  <= arr_d;
            cmp_q  <= cmp_d;
            cap_q  <= cap_d;
            tif_q  <= tif_d;
            uev_q  <= uev_d;
            com_q  <= com_d;
            gate_q <= gate_d;
        end
    end

    // setup registers, output flops and read data
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            slv_q   <= ZERO_W;
            chn_q   <= {30'h0, CCS_OWN};
            oc2_q   <= 1'b0;
            master_trigger_out_q  <= 1'b0;
            irq_q   <= 1'b0;
            dma_q   <= 1'b0;
            rdata_q <= ZERO_W;
        end else begin
            slv_q   <= slv_d;
            chn_q   <= chn_d;
            oc2_q   <= oc2_d;
            master_trigger_out_q  <= master_trigger_out_d;
            irq_q   <= irq_d;
            dma_q   <= dma_d;
            rdata_q <= rdata_d;
        end
    end

    // outputs come straight from their flip-flops
    assign reg_rdata          = rdata_q;
    assign trigger_irq        = irq_q;
    assign trigger_dma        = dma_q;
    assign update_event       = uev_q;
    assign commutation_event  = com_q;
    assign master_trigger_out = master_trigger_out_q;
    assign count_out          = cnt_q;

endmodule

`default_nettype wire
